// *** rtmc_pkg.sv ***
package rtmc_pkg;
   localparam int NUM_BLK = 11;
   localparam int BLK_W = 33;
   localparam int DATA_W = 32;
   localparam int LOCK_POS = 0;
   // block index space: page 0 blocks 0..7, page 1 block k at 7+k for k 1..3
   localparam logic [3:0] IDX_CFG = 4'h0;
   localparam logic [3:0] IDX_FIRST = 4'h1;
   localparam logic [3:0] IDX_PWD = 4'h7;
   localparam logic [3:0] IDX_P1_BASE = 4'h7;
   localparam logic [3:0] IDX_TRC_HI = 4'h8;
   localparam logic [3:0] IDX_TRC_LO = 4'h9;
   localparam logic [3:0] IDX_OPT = 4'hA;
   localparam logic [2:0] P1_LAST = 3'h3;
   localparam logic [31:0] SHADOW_RST = 32'h0000_0000;
   // times in field clocks
   localparam logic [7:0] INIT_FC = 8'hC0;
   localparam logic [7:0] INIT_LAST = INIT_FC - 8'h01;
   localparam logic [11:0] PROG_FC = 12'h2BC;
   localparam logic [11:0] PROG_LAST = PROG_FC - 12'h001;
   localparam logic [7:0] PIE_ZERO_MIN = 8'h0C;
   localparam logic [7:0] PIE_ZERO_MAX = 8'h20;
   localparam logic [7:0] PIE_ONE_MIN = 8'h28;
   localparam logic [7:0] PIE_ONE_MAX = 8'h40;
   localparam logic [7:0] PIE_END = 8'h60;
   // downlink command lengths and opcodes
   localparam logic [5:0] LEN_SHORT = 6'h02;
   localparam logic [5:0] LEN_READ = 6'h06;
   localparam logic [5:0] LEN_WRITE = 6'h26;
   localparam logic [1:0] OP_TRACE = 2'h3;
   localparam logic [1:0] OP_RESET = 2'h0;
   // configuration word fields (bit 31 is sent first)
   localparam int CFG_RATE_LSB = 18;
   localparam int CFG_XMODE_BIT = 16;
   localparam int CFG_MOD_LSB = 11;
   localparam int CFG_MAXBLK_LSB = 5;
   localparam logic [4:0] MOD_PSK1 = 5'h01;
   localparam logic [4:0] MOD_PSK2 = 5'h02;
   localparam logic [4:0] MOD_PSK3 = 5'h03;
   localparam logic [4:0] MOD_FSK1 = 5'h04;
   localparam logic [4:0] MOD_FSK2 = 5'h05;
   localparam logic [4:0] MOD_MANCH = 5'h08;
   localparam logic [4:0] MOD_BIPH = 5'h10;
   // basic-mode divisors, entry k at bits 8k+7..8k
   localparam logic [63:0] BASIC_DIV_TAB =
      64'h8064_4032_2820_1008;
   localparam logic [7:0] XDIV_OFS = 8'h02;
   localparam logic [3:0] FSK_ZERO_PER = 4'h8;
   localparam logic [3:0] FSK_ONE_PER = 4'h5;

   typedef enum logic [2:0] {
      CODE_NRZ, CODE_MANCH, CODE_BIPH, CODE_FSK, CODE_PSK
   } rtmc_coding_t;

   typedef struct packed {
      rtmc_coding_t coding;
      logic [7:0] div;
   } rtmc_mod_cfg_t;

   typedef struct packed {
      logic [7:0] allocation_class_field;
      logic [7:0] maker_code_field;
      logic [4:0] chip_kind_field;
      logic [2:0] silicon_revision_field;
      logic [3:0] year_bcd;
      logic [1:0] quarter;
      logic [13:0] seq_number;
      logic [4:0] wafer_number;
      logic [14:0] die_index_field;
   } rtmc_trace_t;
endpackage

// *** rtmc_modulator.sv ***
`timescale 1ns/1ps
module rtmc_modulator (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic fc_en, // one pulse per field clock
   input wire logic run, // transmission active
   input wire rtmc_pkg::rtmc_mod_cfg_t cfg, // coding and bit divisor
   input wire logic bit_in, // bit being sent
   output logic load_on, // coil load switch
   output logic bit_done // last field clock of the bit
);
   logic [7:0] cnt_q;
   logic [3:0] sub_q;
   logic lvl_q, ph_q, prev_q, load_d;

   wire step = run & fc_en;
   wire last = cnt_q == cfg.div - 8'h01;
   wire bit_start = cnt_q == 8'h00;
   wire [7:0] half_cnt = {1'b0, cfg.div[7:1]};
   wire half = cnt_q == half_cnt;
   wire first_half = cnt_q < half_cnt;
   wire [3:0] fsk_per = bit_in ? rtmc_pkg::FSK_ONE_PER
                               : rtmc_pkg::FSK_ZERO_PER;
   wire fsk_wrap = sub_q >= fsk_per - 4'h1;
   wire fsk_lvl = sub_q < {1'b0, fsk_per[3:1]};
   wire psk_flip = bit_start & (bit_in ^ prev_q);
   assign bit_done = step & last;

   always_comb begin
      unique case (cfg.coding)
         rtmc_pkg::CODE_NRZ: load_d = bit_in;
         rtmc_pkg::CODE_MANCH: load_d = first_half ? ~bit_in : bit_in;
         rtmc_pkg::CODE_BIPH: load_d = lvl_q;
         rtmc_pkg::CODE_FSK: load_d = fsk_lvl;
         rtmc_pkg::CODE_PSK: load_d = cnt_q[0] ^ ph_q ^ psk_flip;
         default: load_d = bit_in;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         sub_q <= 4'h0;
      end else if (!run) begin
         cnt_q <= 8'h00;
         sub_q <= 4'h0;
      end else if (step) begin
         cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
         sub_q <= fsk_wrap ? 4'h0 : sub_q + 4'h1;
      end
   end

   // biphase: toggle at every bit start, once more mid-bit for a one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q <= 1'b0;
         ph_q <= 1'b0;
         prev_q <= 1'b0;
         load_on <= 1'b0;
      end else if (!run) begin
         load_on <= 1'b0;
      end else if (step) begin
         lvl_q <= lvl_q ^ (bit_start | (half & bit_in));
         ph_q <= ph_q ^ psk_flip;
         prev_q <= bit_done ? bit_in : prev_q;
         load_on <= load_d;
      end
   end
endmodule

// *** rtmc_ctrl.sv ***
`timescale 1ns/1ps
module rtmc_ctrl #(
   // arbitrary neutral identity and lot values
   parameter rtmc_pkg::rtmc_trace_t TRACE_ID = 64'h5A3C_2B1D_4E6F_7081
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // power-on reset, active low
   input wire logic rf_clk_pin, // clock recovered from the field
   input wire logic field_pin, // high while field present
   output logic load_on, // coil load switch
   output logic [31:0] mode_shadow_q, // configuration shadow
   output logic [31:0] option_shadow_q, // front-end option shadow
   output logic cmd_error_q, // last command refused
   output logic init_busy // initialisation running
);
   typedef enum logic [2:0] {
      S_INIT, S_READ, S_RX, S_PROG, S_TRACE, S_DIRECT
   } rtmc_state_t;

   rtmc_state_t st_q, st_d;
   logic [2:0] rfc_q, fld_q;
   logic [7:0] init_cnt_q, ivl_q;
   logic [11:0] prog_cnt_q;
   logic [5:0] bits_q;
   logic [37:0] sr_q;
   logic [3:0] prog_idx_q, tx_idx_q, go_idx;
   logic [32:0] prog_blk_q;
   logic [31:0] tx_word_q;
   logic [4:0] tx_bit_q;
   logic tx_load, bit_done;
   logic [32:0] mem [rtmc_pkg::NUM_BLK];

   // returns {valid, index}
   function automatic logic [4:0] blk_index(input logic page,
                                            input logic [2:0] addr);
      if (addr == 3'h0)
         blk_index = {1'b1, rtmc_pkg::IDX_CFG};
      else if (!page)
         blk_index = {1'b1, 1'b0, addr};
      else
         blk_index = {addr <= rtmc_pkg::P1_LAST,
                      rtmc_pkg::IDX_P1_BASE + {1'b0, addr}};
   endfunction

   // trace blocks are factory content, always locked
   function automatic logic [32:0] blk_rd(input logic [3:0] idx,
                                          input logic [32:0] word);
      if (idx == rtmc_pkg::IDX_TRC_HI)
         blk_rd = {TRACE_ID[63:32], 1'b1};
      else if (idx == rtmc_pkg::IDX_TRC_LO)
         blk_rd = {TRACE_ID[31:0], 1'b1};
      else
         blk_rd = word;
   endfunction

   // field clock and field level come from the coil: two flops first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rfc_q <= 3'h0;
         // field is present whenever the tag has power: no false edge
         fld_q <= 3'h7;
      end else begin
         rfc_q <= {rfc_q[1:0], rf_clk_pin};
         fld_q <= {fld_q[1:0], field_pin};
      end
   end

   wire fc_en = rfc_q[1] & ~rfc_q[2];
   wire field = fld_q[1];
   wire gap_start = ~fld_q[1] & fld_q[2];
   wire gap_end = fld_q[1] & ~fld_q[2];
   wire in_gap = ~field;

   // shadows and rate
   wire [31:0] cfg_w = mode_shadow_q;
   wire xmode = cfg_w[rtmc_pkg::CFG_XMODE_BIT];
   wire [5:0] rate_n = cfg_w[rtmc_pkg::CFG_RATE_LSB +: 6];
   wire [2:0] rate_sel = cfg_w[rtmc_pkg::CFG_RATE_LSB +: 3];
   wire [4:0] mod_fld = cfg_w[rtmc_pkg::CFG_MOD_LSB +: 5];
   wire [2:0] max_blk = cfg_w[rtmc_pkg::CFG_MAXBLK_LSB +: 3];
   wire [7:0] xdiv = {1'b0, rate_n, 1'b0} + rtmc_pkg::XDIV_OFS;
   wire [7:0] bdiv = rtmc_pkg::BASIC_DIV_TAB[{rate_sel, 3'h0} +: 8];
   rtmc_pkg::rtmc_mod_cfg_t mcfg;
   assign mcfg.div = xmode ? xdiv : bdiv;
   assign mcfg.coding =
      (mod_fld == rtmc_pkg::MOD_MANCH) ? rtmc_pkg::CODE_MANCH :
      (mod_fld == rtmc_pkg::MOD_BIPH) ? rtmc_pkg::CODE_BIPH :
      (mod_fld == rtmc_pkg::MOD_FSK1 || mod_fld == rtmc_pkg::MOD_FSK2)
         ? rtmc_pkg::CODE_FSK :
      (mod_fld == rtmc_pkg::MOD_PSK1 || mod_fld == rtmc_pkg::MOD_PSK2 ||
       mod_fld == rtmc_pkg::MOD_PSK3) ? rtmc_pkg::CODE_PSK :
      rtmc_pkg::CODE_NRZ;

   // init sequence
   wire init_done = st_q == S_INIT && field && fc_en &&
                    init_cnt_q == rtmc_pkg::INIT_LAST;
   wire shadow_upd = init_done || st_q == S_READ;
   assign init_busy = st_q == S_INIT;

   // downlink bit classification by field-on interval
   wire pie_zero = ivl_q >= rtmc_pkg::PIE_ZERO_MIN &&
                   ivl_q <= rtmc_pkg::PIE_ZERO_MAX;
   wire pie_one = ivl_q >= rtmc_pkg::PIE_ONE_MIN &&
                  ivl_q <= rtmc_pkg::PIE_ONE_MAX;
   wire rx_bit = st_q == S_RX && gap_start && (pie_zero || pie_one);
   wire rx_bad = st_q == S_RX && gap_start &&
                 (!(pie_zero || pie_one) || bits_q == rtmc_pkg::LEN_WRITE);
   wire rx_end = st_q == S_RX && field && ivl_q == rtmc_pkg::PIE_END;

   // command decode
   wire is_short = bits_q == rtmc_pkg::LEN_SHORT;
   wire is_read = bits_q == rtmc_pkg::LEN_READ && sr_q[5] && !sr_q[3];
   wire is_write = bits_q == rtmc_pkg::LEN_WRITE && sr_q[37];
   wire is_trace = is_short && sr_q[1:0] == rtmc_pkg::OP_TRACE;
   wire is_reset = is_short && sr_q[1:0] == rtmc_pkg::OP_RESET;
   wire [4:0] rd_sel = blk_index(sr_q[4], sr_q[2:0]);
   wire [4:0] wr_sel = blk_index(sr_q[36], sr_q[2:0]);
   wire [32:0] wr_blk = blk_rd(wr_sel[3:0], mem[wr_sel[3:0]]);
   wire wr_locked = wr_blk[rtmc_pkg::LOCK_POS];
   wire rd_ok = is_read && rd_sel[4] && rd_sel[3:0] != rtmc_pkg::IDX_OPT;
   wire wr_ok = is_write && wr_sel[4] && !wr_locked;
   wire cmd_ok = is_trace || is_reset || rd_ok || wr_ok;
   wire err_set = rx_bad || (rx_end && !cmd_ok);
   wire err_clr = rx_end && cmd_ok;

   wire prog_fire = st_q == S_PROG && fc_en &&
                    prog_cnt_q == rtmc_pkg::PROG_LAST;
   wire word_end = bit_done && tx_bit_q == 5'h1F;
   wire [32:0] go_blk = blk_rd(go_idx, mem[go_idx]);
   wire [32:0] cfg_blk = blk_rd(rtmc_pkg::IDX_CFG, mem[rtmc_pkg::IDX_CFG]);
   wire [32:0] opt_blk = blk_rd(rtmc_pkg::IDX_OPT, mem[rtmc_pkg::IDX_OPT]);
   wire tx_run = st_q == S_READ || st_q == S_TRACE || st_q == S_DIRECT;
   wire [3:0] rd_next = (tx_idx_q >= {1'b0, max_blk}) ?
                        rtmc_pkg::IDX_FIRST : tx_idx_q + 4'h1;

   always_comb begin
      st_d = st_q;
      tx_load = 1'b0;
      go_idx = rtmc_pkg::IDX_FIRST;
      unique case (st_q)
         S_INIT: begin
            if (init_done) begin
               st_d = S_READ;
               tx_load = 1'b1;
            end
         end
         S_READ, S_TRACE, S_DIRECT: begin
            if (gap_start) begin
               st_d = S_RX;
            end else if (word_end) begin
               tx_load = 1'b1;
               if (st_q == S_READ)
                  go_idx = rd_next;
               else if (st_q == S_TRACE && tx_idx_q == rtmc_pkg::IDX_TRC_HI)
                  go_idx = rtmc_pkg::IDX_TRC_LO;
               else
                  st_d = S_READ;
            end
         end
         S_RX: begin
            if (err_set) begin
               st_d = S_READ;
               tx_load = 1'b1;
            end else if (rx_end) begin
               if (is_reset) begin
                  st_d = S_INIT;
               end else if (is_trace) begin
                  st_d = S_TRACE;
                  tx_load = 1'b1;
                  go_idx = rtmc_pkg::IDX_TRC_HI;
               end else if (rd_ok) begin
                  st_d = S_DIRECT;
                  tx_load = 1'b1;
                  go_idx = rd_sel[3:0];
               end else begin
                  st_d = S_PROG;
               end
            end
         end
         S_PROG: begin
            if (prog_fire) begin
               st_d = S_READ;
               tx_load = 1'b1;
            end
         end
         default: st_d = S_INIT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_INIT;
         init_cnt_q <= 8'h00;
      end else begin
         st_q <= st_d;
         if (st_q != S_INIT || in_gap)
            init_cnt_q <= 8'h00;
         else if (fc_en && !init_done)
            init_cnt_q <= init_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_shadow_q <= rtmc_pkg::SHADOW_RST;
         option_shadow_q <= rtmc_pkg::SHADOW_RST;
         cmd_error_q <= 1'b0;
      end else begin
         if (shadow_upd) begin
            mode_shadow_q <= cfg_blk[32:1];
            option_shadow_q <= opt_blk[32:1];
         end
         if (err_set)
            cmd_error_q <= 1'b1;
         else if (err_clr)
            cmd_error_q <= 1'b0;
      end
   end

   // receiver: interval runs from field return to next gap
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ivl_q <= 8'h00;
         bits_q <= 6'h00;
         sr_q <= 38'h0;
      end else if (st_q != S_RX || gap_end) begin
         ivl_q <= 8'h00;
         if (st_q != S_RX)
            bits_q <= 6'h00;
      end else begin
         if (fc_en && field && ivl_q != rtmc_pkg::PIE_END)
            ivl_q <= ivl_q + 8'h01;
         if (rx_bit && !rx_bad) begin
            sr_q <= {sr_q[36:0], pie_one};
            bits_q <= bits_q + 6'h01;
         end
      end
   end

   // programming: all 33 bits land together after the program time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_cnt_q <= 12'h000;
         prog_idx_q <= rtmc_pkg::IDX_CFG;
         prog_blk_q <= 33'h0;
      end else if (st_q != S_PROG) begin
         prog_cnt_q <= 12'h000;
         if (rx_end && wr_ok) begin
            prog_idx_q <= wr_sel[3:0];
            prog_blk_q <= {sr_q[34:3], sr_q[35]};
         end
      end else if (fc_en) begin
         prog_cnt_q <= prog_cnt_q + 12'h001;
      end
   end

   // nonvolatile content has no reset; its erased state is loaded from
   // outside, so this stays a plain clocked process
   always @(posedge sys_clk) begin
      if (prog_fire)
         mem[prog_idx_q] <= prog_blk_q;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_idx_q <= rtmc_pkg::IDX_FIRST;
         tx_word_q <= 32'h0000_0000;
         tx_bit_q <= 5'h00;
      end else if (tx_load) begin
         tx_idx_q <= go_idx;
         tx_word_q <= go_blk[32:1];
         tx_bit_q <= 5'h00;
      end else if (bit_done) begin
         tx_word_q <= {tx_word_q[30:0], 1'b0};
         tx_bit_q <= tx_bit_q + 5'h01;
      end
   end

   rtmc_modulator u_mod (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fc_en(fc_en),
      .run(tx_run),
      .cfg(mcfg),
      .bit_in(tx_word_q[31]),
      .load_on(load_on),
      .bit_done(bit_done)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_init_end: assert property (init_done |=> st_q == S_READ)
      else $error("init did not end in read");
   a_init_gap: assert property (st_q == S_INIT && in_gap
      |=> init_cnt_q == 8'h00) else $error("gap did not restart init");
   a_shadow_cfg: assert property (st_q == S_READ
      |=> mode_shadow_q == $past(mem[0][32:1]))
      else $error("config shadow stale");
   a_shadow_opt: assert property (st_q == S_READ
      |=> option_shadow_q == $past(mem[10][32:1]))
      else $error("option shadow stale");
   a_skip_cfg: assert property (st_q == S_READ && !tx_load
      |-> tx_idx_q != rtmc_pkg::IDX_CFG && tx_idx_q < rtmc_pkg::IDX_TRC_HI)
      else $error("read sent config or option");
   a_lock_refuse: assert property (rx_end && is_write && wr_locked
      |=> st_q != S_PROG) else $error("locked block accepted");
   a_prog_whole: assert property (prog_fire
      |=> mem[$past(prog_idx_q)] == $past(prog_blk_q))
      else $error("block not programmed whole");
   a_pie_error: assert property (rx_bad
      |=> cmd_error_q && st_q == S_READ) else $error("bad bit not flagged");
   a_rate_even: assert property (xmode |-> !mcfg.div[0] &&
      mcfg.div >= 8'h02 && mcfg.div <= 8'h80) else $error("bad rate");
   a_trace_seq: assert property (st_q == S_TRACE && word_end
      && tx_idx_q == rtmc_pkg::IDX_TRC_HI |=> st_q == S_TRACE &&
      tx_idx_q == rtmc_pkg::IDX_TRC_LO) else $error("trace order wrong");

   c_init: cover property (init_done);
   c_write: cover property (prog_fire);
   c_trace: cover property (st_q == S_TRACE && word_end);
   c_error: cover property (rx_bad);
endmodule

// *** rtmc_reader.sv ***
`timescale 1ns/1ps
module rtmc_reader (
   output logic rf_clk_pin, // field clock seen by the tag
   output logic field_pin, // field on, low during a gap
   input wire logic load_on // tag load switch
);
   logic osc = 1'b0;
   logic [1023:0] hist = '0;

   initial field_pin = 1'b1;

   always #160 osc = ~osc;

   // no field means no clock, so a gap also stops the field clock
   assign rf_clk_pin = osc & field_pin;

   // one load sample per field clock, newest at bit 0
   always @(posedge rf_clk_pin) hist <= {hist[1022:0], load_on};

   task automatic fc(input int n);
      repeat (n) @(negedge osc);
   endtask

   task automatic gap();
      field_pin <= 1'b0;
      fc(2);
      field_pin <= 1'b1;
   endtask

   task automatic pulse(input int len);
      fc(len);
      gap();
   endtask

   // intervals sit well inside the decode windows, first bit is the msb
   task automatic send(input logic [37:0] bits, input int n);
      gap();
      for (int i = n - 1; i >= 0; i--) begin
         pulse(bits[i] ? 48 : 16);
      end
   endtask
endmodule

// *** rtmc_ctrl_bench.sv ***
`timescale 1ns/1ps
module rtmc_ctrl_bench;
   // identity and lot values below are arbitrary
   localparam rtmc_pkg::rtmc_trace_t TRC = '{
      allocation_class_field: 8'h3C, maker_code_field: 8'h5A,
      chip_kind_field: 5'h0B, silicon_revision_field: 3'h5,
      year_bcd: 4'h7, quarter: 2'h2, seq_number: 14'h1A2B,
      wafer_number: 5'h13, die_index_field: 15'h4D2E};
   localparam logic [63:0] TRC_EXP = {8'h3C, 8'h5A, 5'h0B, 3'h5,
      4'h7, 2'h2, 14'h1A2B, 5'h13, 15'h4D2E};
   // basic mode, RF/8, plain nrz so the uplink can be sampled directly
   localparam logic [31:0] CFG_A = 32'h8000_0040;
   // extended mode, RF/(2*3+2), manchester
   localparam logic [31:0] CFG_B = 32'h000D_4000;
   localparam logic [31:0] OPT_A = 32'h0000_0006;

   logic sys_clk;
   logic rst_n;
   logic rf_clk_pin;
   logic field_pin;
   logic load_on;
   logic [31:0] mode_shadow_q;
   logic [31:0] option_shadow_q;
   logic cmd_error_q;
   logic init_busy;
   int num_errors;
   int checks;

   rtmc_ctrl #(.TRACE_ID(TRC)) u_rtmc_ctrl (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .rf_clk_pin(rf_clk_pin),
      .field_pin(field_pin),
      .load_on(load_on),
      .mode_shadow_q(mode_shadow_q),
      .option_shadow_q(option_shadow_q),
      .cmd_error_q(cmd_error_q),
      .init_busy(init_busy)
   );

   rtmc_reader u_rtmc_reader (
      .rf_clk_pin(rf_clk_pin),
      .field_pin(field_pin),
      .load_on(load_on)
   );

   always #20 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic done(input string name);
      $display("test %s finished, errors so far %0d", name, num_errors);
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // write waits out end detection plus the whole programming time
   task automatic wcmd(input logic p, input logic lk, input logic [31:0] d,
                       input logic [2:0] a);
      u_rtmc_reader.send({1'b1, p, lk, d, a}, 38);
      u_rtmc_reader.fc(820);
   endtask

   // look for the 64 trace bits at one sample per 8-clock bit, mid-bit
   function automatic logic find_trace();
      logic [63:0] w;
      for (int s = 0; s <= 515; s++) begin
         for (int j = 0; j < 64; j++) w[j] = u_rtmc_reader.hist[s + 4 + 8 * j];
         if (w === TRC_EXP) return 1'b1;
      end
      return 1'b0;
   endfunction

   function automatic logic [31:0] flag(input logic b);
      return {31'h0, b};
   endfunction

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      num_errors = 0;
      checks = 0;
      // the array powers up unknown: start from an erased, unlocked memory
      for (int k = 0; k < rtmc_pkg::NUM_BLK; k++) begin
         u_rtmc_ctrl.mem[k] = 33'h0;
      end
      repeat (4) @(posedge sys_clk);
      chk({29'h0, init_busy, cmd_error_q, load_on}, 32'h4);
      chk(mode_shadow_q, 32'h0);
      chk(option_shadow_q, 32'h0);
      rst_n <= 1'b1;
      u_rtmc_reader.fc(100);
      u_rtmc_reader.gap();
      u_rtmc_reader.fc(185);
      chk(flag(init_busy), 32'h1);
      u_rtmc_reader.fc(20);
      chk(flag(init_busy), 32'h0);
      done("init");

      wcmd(1'b0, 1'b0, CFG_A, 3'h0);
      chk(mode_shadow_q, CFG_A);
      chk(flag(cmd_error_q), 32'h0);
      wcmd(1'b1, 1'b0, OPT_A, 3'h3);
      chk(option_shadow_q, OPT_A);
      done("writes");

      u_rtmc_reader.gap();
      u_rtmc_reader.pulse(36);
      u_rtmc_reader.fc(130);
      chk(flag(cmd_error_q), 32'h1);
      chk(mode_shadow_q, CFG_A);
      done("bad interval");

      u_rtmc_reader.send(38'h3, 2);
      u_rtmc_reader.fc(700);
      chk(flag(cmd_error_q), 32'h0);
      chk(flag(find_trace()), 32'h1);
      done("trace");

      u_rtmc_reader.send(38'h33, 6);
      u_rtmc_reader.fc(130);
      chk(flag(cmd_error_q), 32'h1);
      done("option read");

      u_rtmc_reader.send(38'h0, 2);
      u_rtmc_reader.fc(100);
      chk(flag(init_busy), 32'h1);
      u_rtmc_reader.fc(200);
      chk({30'h0, init_busy, cmd_error_q}, 32'h0);
      chk(mode_shadow_q, CFG_A);
      chk(option_shadow_q, OPT_A);
      done("reset command");

      wcmd(1'b1, 1'b1, CFG_B, 3'h0);
      chk(mode_shadow_q, CFG_B);
      wcmd(1'b0, 1'b0, CFG_A, 3'h0);
      chk(flag(cmd_error_q), 32'h1);
      chk(mode_shadow_q, CFG_B);
      done("lock");
      conclude();
   end

   // tests need roughly 2.7 ms of simulated time
   initial begin
      #3_600_000;
      num_errors++;
      $display("watchdog expired at t=%0t", $time);
      conclude();
   end
endmodule
